// File: bench/pcs_link_properties.sv
// Concurrent checks on the sensor to controller link
`timescale 1ns/1ns
module pcs_link_properties
(
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic arst_n_in,
    // Link pins
    input wire logic timing,
    input wire logic result_dev_oe,
    input wire logic result_ctl_oe,
    input wire logic flag_dev_oe,
    input wire logic result_lvl,
    input wire logic flag_lvl
);
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (!arst_n_in);
    logic        timing_q;
    logic [19:0] cnt_q;
    logic [19:0] pulse_q;
    logic [19:0] len_q [2];
    logic [3:0]  age_q;
    logic [7:0]  ctl_q;
    logic [7:0]  lo_q;
    wire         edge_w = timing != timing_q;
    ////////////////////////////////////////////////////////////////
    // Half lengths, pulse lengths and low runs
    always_ff @(posedge clk_sys_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            timing_q <= 1'b0;
            cnt_q    <= 20'h00000;
            age_q    <= 4'hf;
            len_q    <= '{20'h00000, 20'h00000};
        end
        else
        begin
            timing_q <= timing;
            cnt_q    <= edge_w ? 20'h00000 : cnt_q + 20'h00001;
            age_q    <= edge_w ? 4'h0 : (age_q == 4'hf ? age_q : age_q + 4'h1);
            if (edge_w)
                len_q[timing_q] <= cnt_q + 20'h00001;
        end
    end
    always_ff @(posedge clk_sys_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            pulse_q <= 20'h00000;
            ctl_q   <= 8'h00;
            lo_q    <= 8'h00;
        end
        else
        begin
            pulse_q <= result_dev_oe ? pulse_q + 20'h00001 : 20'h00000;
            ctl_q   <= result_ctl_oe ? ctl_q + 8'h01 : 8'h00;
            lo_q    <= result_lvl ? 8'h00 : (lo_q == 8'hff ? lo_q : lo_q + 8'h01);
        end
    end
    ////////////////////////////////////////////////////////////////
    fault_release_a: assert property (flag_dev_oe |-> !result_dev_oe)
        else $error("result driven while fault latched");
    pulse_start_a: assert property ($rose(result_dev_oe) |-> age_q <= 4'h4)
        else $error("result pulse not tied to a timing edge");
    duty_range_a: assert property ($fell(result_dev_oe) && !flag_dev_oe
        && len_q[timing_q] != 0 |-> pulse_q * 10 + 10 >= len_q[timing_q]
        && pulse_q * 10 <= len_q[timing_q] * 3 + 10)
        else $error("result pulse outside duty span");
    edge_quiet_a: assert property ($changed(timing) |-> !result_dev_oe)
        else $error("result pulse runs across a timing edge");
    flag_hold_a: assert property (result_lvl [*4] ##0 flag_dev_oe |=> flag_dev_oe)
        else $error("fault released without clear");
    clear_min_a: assert property ($fell(flag_dev_oe) |-> lo_q >= 8'd125)
        else $error("fault cleared by short low pulse");
    clear_run_a: assert property ($fell(result_ctl_oe) |-> ctl_q == 8'd127)
        else $error("clear pulse length wrong");
    timing_hold_a: assert property ($changed(timing) |=> $stable(timing) [*8])
        else $error("timing half too short");
    flag_pin_a: assert property (flag_dev_oe |-> !flag_lvl)
        else $error("flag line not low while latched");
    cover property ($fell(result_dev_oe));
    cover property ($rose(flag_dev_oe));
    cover property ($fell(flag_dev_oe));
endmodule

// File: bench/phase_current_pwm_readout_bench.sv
// Self-checking bench for the sensor and controller pair
`timescale 1ns/1ns
module phase_current_pwm_readout_bench;
    logic               clk_sys_in, arst_n_in, auto_clear_in, clear_req_in, seen;
    logic signed [11:0] sample_in;
    logic [11:0]        threshold_in;
    logic [19:0]        half_period_in, off_time_out [2], period_out [2];
    logic [1:0]         gain_in, gain_out;
    logic               result_valid_out, result_ch_out, fault_out, fault_ctl;
    int                 errors, comparisons;
    pcs_link_if link ();
    pcs_sensor pcs_sensor_inst (.clk_sys_in, .arst_n_in, .link(link.device), .sample_in,
        .threshold_in, .fault_out, .gain_out);
    pcs_controller pcs_controller_inst (.clk_sys_in, .arst_n_in, .link(link.host),
        .half_period_in, .gain_in, .auto_clear_in, .clear_req_in, .off_time_out,
        .period_out, .result_valid_out, .result_ch_out, .fault_out(fault_ctl));
    pcs_link_properties pcs_link_properties_inst (.clk_sys_in, .arst_n_in,
        .timing(link.timing), .result_dev_oe(link.result_dev_oe),
        .result_ctl_oe(link.result_ctl_oe), .flag_dev_oe(link.flag_dev_oe),
        .result_lvl(link.result_lvl), .flag_lvl(link.flag_lvl));
    ////////////////////////////////////////////////////////////////
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys_in);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input int tol);
        comparisons++;
        if (^got === 1'bx || got + tol < exp || got > exp + tol)
        begin
            errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish;
        $display("comparisons=%0d errors=%0d", comparisons, errors);
        if (errors == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic duty(input logic signed [11:0] s, input logic [31:0] exp);
        sample_in <= s;
        for (int i = 0; i < 6; i++)
        begin
            cyc(1);
            for (int k = 0; k < 900 && result_valid_out !== 1'b1; k++)
                cyc(1);
        end
        for (int c = 0; c < 2; c++)
            chk({12'h000, off_time_out[c]} * 1000 / {12'h000, period_out[c]}, exp, 4);
    endtask
    task automatic clr;
        clear_req_in <= 1'b1;
        cyc(1);
        clear_req_in <= 1'b0;
    endtask
    ////////////////////////////////////////////////////////////////
    initial
    begin
        clk_sys_in = 1'b0;
        forever #2 clk_sys_in = ~clk_sys_in;
    end
    initial
    begin
        cyc(60000);
        errors++;
        tally_and_finish();
    end
    initial
    begin
        {arst_n_in, auto_clear_in, clear_req_in, sample_in} = '0;
        {threshold_in, half_period_in, gain_in} = {12'h3e8, 20'h000c8, 2'h2};
        cyc(12);
        arst_n_in <= 1'b1;
        duty(12'h000, 200);
        duty(12'h100, 100);
        duty(12'hf00, 300);
        half_period_in <= 20'h00078;
        duty(12'h080, 150);
        chk(gain_out, 2'h2, 0);
        threshold_in <= 12'h0c8;
        sample_in <= 12'h12c;
        cyc(600);
        sample_in <= 12'h000;
        cyc(5);
        sample_in <= 12'h12c;
        cyc(600);
        chk(fault_out, 1'b0, 0);
        cyc(400);
        chk(fault_out, 1'b1, 0);
        chk(fault_ctl, 1'b1, 0);
        clr();
        seen = 1'b0;
        repeat (400)
        begin
            cyc(1);
            if (fault_out === 1'b0)
                seen = 1'b1;
        end
        chk(seen, 1'b1, 0);
        chk(fault_out, 1'b1, 0);
        sample_in <= 12'h000;
        clr();
        cyc(400);
        chk(fault_out, 1'b0, 0);
        auto_clear_in <= 1'b1;
        sample_in <= 12'hed4;
        cyc(900);
        sample_in <= 12'h000;
        cyc(400);
        chk(fault_out, 1'b0, 0);
        tally_and_finish();
    end
endmodule

// File: rtl/pcs_controller.sv
// Controller end: timing generation and duty decoding
`timescale 1ns/1ns
module pcs_controller
(
    // Clock and reset
    input  wire logic                 clk_sys_in,
    input  wire logic                 arst_n_in,
    // Link
    pcs_link_if.host                  link,
    // Setup
    input  wire logic [19:0]          half_period_in,
    input  wire logic [1:0]           gain_in,
    input  wire logic                 auto_clear_in,
    input  wire logic                 clear_req_in,
    // Results
    output logic [19:0]               off_time_out [2],
    output logic [19:0]               period_out [2],
    output logic                      result_valid_out,
    output logic                      result_ch_out,
    output logic                      fault_out
);
    logic [19:0] cnt_q, off_cnt_q, clr_cnt_q;
    logic        tim_q, gl_q, gh_q, tie_q, clr_q;
    logic [1:0]  res_s_q, flg_s_q;
    wire  wrap = cnt_q >= half_period_in - 20'h00001;
    wire  clr_done = 32'(clr_cnt_q) + 1 >= pcs_pkg::CLEAR_CYC + 2;

    ////////////////////////////////////////////////////////////////////////////
    // Timing aligned with carrier halves; off time per channel
    always_ff @(posedge clk_sys_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            cnt_q <= '0; off_cnt_q <= '0; tim_q <= 1'b0;
            res_s_q <= 2'h3; flg_s_q <= 2'h3;
            off_time_out[0] <= '0; off_time_out[1] <= '0;
            period_out[0] <= '0; period_out[1] <= '0;
            result_valid_out <= 1'b0; result_ch_out <= 1'b0; fault_out <= 1'b0;
            gl_q <= 1'b0; gh_q <= 1'b0; tie_q <= 1'b0; clr_q <= 1'b0; clr_cnt_q <= '0;
        end
        else
        begin
            res_s_q <= {res_s_q[0], link.result_lvl};
            flg_s_q <= {flg_s_q[0], link.flag_lvl};
            fault_out <= ~flg_s_q[1];
            gl_q <= gain_in[0];
            gh_q <= gain_in[1];
            tie_q <= auto_clear_in;
            result_valid_out <= 1'b0;
            if (wrap)
            begin
                cnt_q <= '0;
                tim_q <= ~tim_q;
                // Channel of the period just ended, stored apart
                off_time_out[tim_q ? 0 : 1] <= off_cnt_q;
                period_out[tim_q ? 0 : 1] <= half_period_in;
                result_ch_out <= ~tim_q;
                result_valid_out <= 1'b1;
                off_cnt_q <= '0;
            end
            else
            begin
                cnt_q <= cnt_q + 1'b1;
                if (!res_s_q[1])
                    off_cnt_q <= off_cnt_q + 1'b1;
            end
            if (clr_q)
            begin
                clr_cnt_q <= clr_cnt_q + 1'b1;
                if (clr_done)
                    clr_q <= 1'b0;
            end
            else if (clear_req_in)
            begin
                clr_q <= 1'b1;
                clr_cnt_q <= '0;
            end
        end
    end

    assign link.timing          = tim_q;
    assign link.gain_low        = gl_q;
    assign link.gain_high       = gh_q;
    assign link.tie_flag_result = tie_q;
    assign link.result_ctl_oe   = clr_q;
    assign link.flag_ctl_oe     = 1'b0;
endmodule

// File: rtl/pcs_link_if.sv
// Pin-level link between sensor and controller
`timescale 1ns/1ns
interface pcs_link_if;
    logic timing;
    logic result_dev_oe;
    logic result_ctl_oe;
    logic flag_dev_oe;
    logic flag_ctl_oe;
    logic tie_flag_result;
    logic gain_low;
    logic gain_high;
    wire  result_lvl = ~(result_dev_oe | result_ctl_oe |
                         (tie_flag_result & flag_dev_oe));
    wire  flag_lvl   = ~(flag_dev_oe | flag_ctl_oe);
    modport device (input timing, input result_lvl, input flag_lvl, input gain_low,
                    input gain_high, output result_dev_oe, output flag_dev_oe);
    modport host   (output timing, input result_lvl, input flag_lvl, output gain_low,
                    output gain_high, output result_ctl_oe, output flag_ctl_oe,
                    output tie_flag_result);
endinterface

// File: rtl/pcs_pkg.sv
// Constants for the phase current pulse readout link
package pcs_pkg;
    localparam int unsigned CLK_MHZ = 250;
    // Timing in nanoseconds, with the derived counts in clock cycles
    localparam int unsigned DEBOUNCE_MIN_NS = 2700;
    localparam int unsigned DEBOUNCE_MAX_NS = 4700;
    localparam int unsigned CLEAR_PULSE_NS = 500;
    localparam int unsigned DEBOUNCE_CYC = (DEBOUNCE_MIN_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned CLEAR_CYC = (CLEAR_PULSE_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned CNT_W = 12;
    // Sample is signed input in 1/1024 volt units; duty in per-mille
    localparam int unsigned SAMPLE_W = 12;
    localparam int unsigned DUTY_W = 10;
    localparam logic [DUTY_W-1:0] DUTY_MIN = 10'h064;
    localparam logic [DUTY_W-1:0] DUTY_ZERO = 10'h0c8;
    localparam logic [DUTY_W-1:0] DUTY_MAX = 10'h12c;
    localparam logic [DUTY_W-1:0] PERMILLE = 10'h3e8;
    localparam int unsigned PERIOD_W = 20;
    localparam logic [1:0] GAIN_RESET = 2'h0;
endpackage

// File: rtl/pcs_sensor.sv
// Sensor end: duty encoding and over-current flag
`timescale 1ns/1ns
module pcs_sensor
(
    // Clock and reset
    input  wire logic                          clk_sys_in,
    input  wire logic                          arst_n_in,
    // Link
    pcs_link_if.device                         link,
    // Sense data
    input  wire logic signed [pcs_pkg::SAMPLE_W-1:0] sample_in,
    input  wire logic [pcs_pkg::SAMPLE_W-1:0]  threshold_in,
    // Status
    output logic                               fault_out,
    output logic [1:0]                         gain_out
);
    localparam int unsigned PW = pcs_pkg::PERIOD_W;
    localparam int unsigned DW = pcs_pkg::DUTY_W;
    localparam int unsigned CW = pcs_pkg::CNT_W;
    localparam int unsigned SW = pcs_pkg::SAMPLE_W;

    ////////////////////////////////////////////////////////////////////////////
    // Duty from sample: 200 - 40%/V, clamped
    function automatic logic [DW-1:0] duty_of(input logic signed [pcs_pkg::SAMPLE_W-1:0] s);
        logic signed [15:0] d;
        d = 16'sh00c8 - 16'((32'(signed'(s)) * 400) >>> 10);
        if (d < signed'(16'(pcs_pkg::DUTY_MIN)))
            duty_of = pcs_pkg::DUTY_MIN;
        else if (d > signed'(16'(pcs_pkg::DUTY_MAX)))
            duty_of = pcs_pkg::DUTY_MAX;
        else
            duty_of = DW'(d);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    logic [1:0] tim_s_q, res_s_q, gl_s_q, gh_s_q;
    always_ff @(posedge clk_sys_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            tim_s_q <= 2'h0;
            res_s_q <= 2'h3;
            gl_s_q  <= 2'h0;
            gh_s_q  <= 2'h0;
        end
        else
        begin
            tim_s_q <= {tim_s_q[0], link.timing};
            res_s_q <= {res_s_q[0], link.result_lvl};
            gl_s_q  <= {gl_s_q[0], link.gain_low};
            gh_s_q  <= {gh_s_q[0], link.gain_high};
        end
    end
    logic tim_prev_q;
    wire  tim    = tim_s_q[1];
    wire  edge_w = tim ^ tim_prev_q;
    wire  res_lo = ~res_s_q[1];

    ////////////////////////////////////////////////////////////////////////////
    // Per-channel period measure and result drive
    logic [PW-1:0] per_cnt_q;
    logic [PW-1:0] len_q [2];
    logic [DW-1:0] duty_q [2];
    logic [PW-1:0] off_q;
    logic          drive_q;
    logic          ch_q;
    logic          fault_q;
    wire           fault_set;
    wire  ch_w   = ~tim;
    wire [PW+DW-1:0] off_prod = len_q[ch_w] * duty_q[ch_w];
    wire [PW-1:0] off_w = PW'(off_prod / pcs_pkg::PERMILLE);
    always_ff @(posedge clk_sys_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            tim_prev_q <= 1'b0;
            per_cnt_q  <= '0;
            len_q[0]   <= '0;
            len_q[1]   <= '0;
            duty_q[0]  <= pcs_pkg::DUTY_ZERO;
            duty_q[1]  <= pcs_pkg::DUTY_ZERO;
            off_q      <= '0;
            drive_q    <= 1'b0;
            ch_q       <= 1'b0;
        end
        else
        begin
            tim_prev_q <= tim;
            if (edge_w)
            begin
                // Close ending half period of its own channel
                len_q[ch_q]  <= per_cnt_q + 1'b1;
                duty_q[ch_q] <= duty_of(sample_in);
                ch_q         <= ch_w;
                per_cnt_q    <= '0;
                off_q        <= off_w;
                drive_q      <= (off_w != '0) && !fault_q;
            end
            else
            begin
                if (per_cnt_q != '1)
                    per_cnt_q <= per_cnt_q + 1'b1;
                if (off_q != '0)
                    off_q <= off_q - 1'b1;
                if (off_q <= PW'(1))
                    drive_q <= 1'b0;
            end
            if (fault_q || fault_set)
                drive_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Over-current debounce, latch and clear
    wire [pcs_pkg::SAMPLE_W-1:0] mag = sample_in[pcs_pkg::SAMPLE_W-1] ?
                                       SW'(-sample_in) : sample_in;
    wire over = mag > threshold_in;
    logic [CW-1:0] deb_q, clr_q;
    logic          pending_q;
    wire  forced_lo = res_lo && !drive_q;
    assign fault_set = !fault_q && over &&
                       (pending_q ? edge_w : (32'(deb_q) + 1 >= pcs_pkg::DEBOUNCE_CYC));
    always_ff @(posedge clk_sys_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            deb_q     <= '0;
            clr_q     <= '0;
            fault_q   <= 1'b0;
            pending_q <= 1'b0;
            fault_out <= 1'b0;
            gain_out  <= pcs_pkg::GAIN_RESET;
        end
        else
        begin
            gain_out  <= {gh_s_q[1], gl_s_q[1]};
            fault_out <= fault_q;
            deb_q     <= over ? ((deb_q == '1) ? deb_q : deb_q + 1'b1) : '0;
            if (!fault_q)
            begin
                clr_q <= '0;
                if (fault_set)
                begin
                    fault_q   <= 1'b1;
                    pending_q <= 1'b0;
                end
                else if (!over)
                    pending_q <= 1'b0;
            end
            else if (forced_lo)
            begin
                clr_q <= clr_q + 1'b1;
                if (32'(clr_q) + 1 >= pcs_pkg::CLEAR_CYC)
                begin
                    fault_q   <= 1'b0;
                    pending_q <= over;
                    clr_q     <= '0;
                end
            end
            else
                clr_q <= '0;
        end
    end

    assign link.result_dev_oe = drive_q;
    assign link.flag_dev_oe   = fault_q;
endmodule
